// ===== shared/postproc_pkg.sv
package postproc_pkg;

    localparam int DATA_W = 32;
    localparam int DEPTH_W = 7;
    localparam int DEPTH_MAX = 100;
    localparam logic [6:0] DEPTH_MIN = 7'h02;
    localparam logic [6:0] DEPTH_TOP = 7'h64;
    localparam logic [6:0] DEPTH_RST = 7'h0a;

    // digit codes 4, 5, 6 mean 4.5, 5.5 and 6.5 digits
    localparam logic [2:0] DIG_4P5 = 3'h4;
    localparam logic [2:0] DIG_6P5 = 3'h6;
    localparam logic [2:0] DIGITS_RST = 3'h6;

    // byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DEPTH = 8'h04;
    localparam logic [7:0] OFF_DIGITS = 8'h08;
    localparam logic [7:0] OFF_CLEAR = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_RESULT = 8'h14;
    localparam logic [7:0] OFF_MATH = 8'h20;
    localparam logic [7:0] OFF_MATH_END = 8'h50;
    localparam logic [1:0] MATH_GAIN = 2'h0;
    localparam logic [1:0] MATH_OFFS = 2'h1;
    localparam logic [1:0] MATH_REL = 2'h2;

    // control fields
    localparam int CTRL_FILT = 0;
    localparam int CTRL_MATH = 1;
    localparam int CTRL_REL = 2;
    localparam int CTRL_WIN_LO = 4;
    localparam int CTRL_BUF = 8;
    localparam int CTRL_FN_LO = 12;
    localparam int CLEAR_BIT = 0;
    localparam int STAT_LAMP = 0;
    localparam int STAT_EMPTY = 1;
    localparam int STAT_DIG_LO = 4;

    localparam int GAIN_FRAC = 16;
    localparam logic [31:0] GAIN_RST = 32'h0001_0000;
    localparam logic [31:0] OFFS_RST = 32'h0000_0000;
    localparam logic [31:0] REL_RST = 32'h0000_0000;

    // window divisors of the active range
    localparam logic [31:0] DIV_0P01 = 32'h0000_2710;
    localparam logic [31:0] DIV_0P1 = 32'h0000_03e8;
    localparam logic [31:0] DIV_1 = 32'h0000_0064;
    localparam logic [31:0] DIV_10 = 32'h0000_000a;

    typedef enum logic [2:0] {
        FN_VOLT = 3'b000,
        FN_CURR = 3'b001,
        FN_CONC = 3'b010,
        FN_BTEST = 3'b011,
        FN_BSIM = 3'b100
    } func_t;

    typedef enum logic [2:0] {
        WIN_0P01 = 3'b000,
        WIN_0P1 = 3'b001,
        WIN_1 = 3'b010,
        WIN_10 = 3'b011,
        WIN_100 = 3'b100
    } win_t;

    typedef struct packed {
        logic valid;
        logic bat;
        logic filt;
        func_t func;
        logic [2:0] digits;
        logic signed [31:0] prim;
        logic signed [31:0] pre;
        logic signed [31:0] other;
    } pipe_t;

endpackage

// ===== rtl/reading_postprocess_pipeline.sv
`timescale 1ns/1ps
module reading_postprocess_pipeline #(
    parameter int DEPTH_CAP = postproc_pkg::DEPTH_MAX
) (
    // clock, reset, enable
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic CE,
    // avalon-mm slave
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // readings from the converter
    input wire logic RD_VALID,
    input wire logic signed [31:0] RD_VOLTAGE,
    input wire logic signed [31:0] RD_CURRENT,
    input wire logic [31:0] RD_RANGE,
    // processed results
    output logic OUT_VALID,
    output logic signed [31:0] OUT_VOLTAGE,
    output logic signed [31:0] OUT_CURRENT,
    output logic signed [31:0] BUF_VALUE,
    output logic [2:0] OUT_DIGITS,
    output logic OUT_UNIT_X,
    output logic OUT_LAMP
);

    localparam int SUM_W = 40;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // {hit, function index, register within function}
    function automatic logic [4:0] math_dec(input logic [7:0] a);
        logic [3:0] f;
        f = a[7:4] - postproc_pkg::OFF_MATH[7:4];
        if (a >= postproc_pkg::OFF_MATH && a < postproc_pkg::OFF_MATH_END
            && a[3:2] != 2'h3) begin
            return {1'b1, f[1:0], a[3:2]};
        end else begin
            return 5'h00;
        end
    endfunction

    function automatic logic signed [32:0] win_hw(input logic [31:0] rng,
                                                  input logic [2:0] sel);
        logic [31:0] q;
        case (sel)
            postproc_pkg::WIN_0P01: q = rng / postproc_pkg::DIV_0P01;
            postproc_pkg::WIN_0P1: q = rng / postproc_pkg::DIV_0P1;
            postproc_pkg::WIN_1: q = rng / postproc_pkg::DIV_1;
            default: q = rng / postproc_pkg::DIV_10;
        endcase
        return $signed({1'b0, q});
    endfunction

    function automatic logic is_bat(input postproc_pkg::func_t fn);
        return fn == postproc_pkg::FN_BTEST || fn == postproc_pkg::FN_BSIM;
    endfunction

    // control registers
    logic filt_en, math_en, rel_en, buf_after;
    logic [2:0] win_sel;
    postproc_pkg::func_t func;
    logic [6:0] depth;
    logic [2:0] digits;
    logic signed [31:0] gain [3];
    logic signed [31:0] offs [3];
    logic signed [31:0] rel [3];
    logic signed [31:0] result;

    // filter state
    logic signed [31:0] stack [DEPTH_CAP];
    logic signed [SUM_W-1:0] sum;
    logic [6:0] ptr;
    logic empty;
    logic signed [31:0] filt_value;

    postproc_pkg::pipe_t st1, st2, st3;

    // bus decode
    logic bus_wr;
    logic [31:0] cur_word, new_word;
    logic [4:0] mdec;
    logic depth_wr, ctrl_wr, clear_wr;
    logic [1:0] fidx_bus;
    logic [6:0] next_depth;
    logic [2:0] next_win, next_fn, next_dig;

    assign bus_wr = AVS_WRITE && !AVS_WAITREQUEST;
    assign mdec = math_dec(AVS_ADDRESS);
    assign fidx_bus = mdec[3:2];

    always_comb begin
        cur_word = 32'h0000_0000;
        if (AVS_ADDRESS == postproc_pkg::OFF_CTRL) begin
            cur_word[postproc_pkg::CTRL_FILT] = filt_en;
            cur_word[postproc_pkg::CTRL_MATH] = math_en;
            cur_word[postproc_pkg::CTRL_REL] = rel_en;
            cur_word[postproc_pkg::CTRL_WIN_LO +: 3] = win_sel;
            cur_word[postproc_pkg::CTRL_BUF] = buf_after;
            cur_word[postproc_pkg::CTRL_FN_LO +: 3] = func;
        end else if (AVS_ADDRESS == postproc_pkg::OFF_DEPTH) begin
            cur_word[6:0] = depth;
        end else if (AVS_ADDRESS == postproc_pkg::OFF_DIGITS) begin
            cur_word[2:0] = digits;
        end else if (AVS_ADDRESS == postproc_pkg::OFF_STATUS) begin
            cur_word[postproc_pkg::STAT_LAMP] = OUT_LAMP;
            cur_word[postproc_pkg::STAT_EMPTY] = empty;
            cur_word[postproc_pkg::STAT_DIG_LO +: 3] = OUT_DIGITS;
        end else if (AVS_ADDRESS == postproc_pkg::OFF_RESULT) begin
            cur_word = result;
        end else if (mdec[4] && mdec[1:0] == postproc_pkg::MATH_GAIN) begin
            cur_word = gain[fidx_bus];
        end else if (mdec[4] && mdec[1:0] == postproc_pkg::MATH_OFFS) begin
            cur_word = offs[fidx_bus];
        end else if (mdec[4]) begin
            cur_word = rel[fidx_bus];
        end
    end

    assign new_word = merge(cur_word, AVS_WRITEDATA, AVS_BYTEENABLE);
    assign next_depth = new_word[6:0];
    assign next_win = new_word[postproc_pkg::CTRL_WIN_LO +: 3];
    assign next_fn = new_word[postproc_pkg::CTRL_FN_LO +: 3];
    assign next_dig = new_word[2:0];
    assign ctrl_wr = bus_wr && AVS_ADDRESS == postproc_pkg::OFF_CTRL;
    assign clear_wr = bus_wr && AVS_ADDRESS == postproc_pkg::OFF_CLEAR
        && AVS_BYTEENABLE[0] && AVS_WRITEDATA[postproc_pkg::CLEAR_BIT];
    assign depth_wr = bus_wr && AVS_ADDRESS == postproc_pkg::OFF_DEPTH
        && next_depth >= postproc_pkg::DEPTH_MIN
        && next_depth <= postproc_pkg::DEPTH_TOP
        && next_depth != depth;

    // one wait cycle, then acknowledge
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= 32'h0000_0000;
        end else if (CE) begin
            if ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) begin
                AVS_WAITREQUEST <= 1'b0;
            end else begin
                AVS_WAITREQUEST <= 1'b1;
            end
            if (AVS_READ && AVS_WAITREQUEST) begin
                AVS_READDATA <= cur_word;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            filt_en <= 1'b0;
            math_en <= 1'b0;
            rel_en <= 1'b0;
            buf_after <= 1'b0;
            win_sel <= postproc_pkg::WIN_0P01;
            func <= postproc_pkg::FN_VOLT;
            depth <= postproc_pkg::DEPTH_RST;
            digits <= postproc_pkg::DIGITS_RST;
        end else if (CE) begin
            if (ctrl_wr) begin
                filt_en <= new_word[postproc_pkg::CTRL_FILT];
                math_en <= new_word[postproc_pkg::CTRL_MATH];
                rel_en <= new_word[postproc_pkg::CTRL_REL];
                buf_after <= new_word[postproc_pkg::CTRL_BUF];
                if (next_win <= postproc_pkg::WIN_100) begin
                    win_sel <= next_win;
                end
                if (next_fn <= postproc_pkg::FN_BSIM) begin
                    func <= postproc_pkg::func_t'(next_fn);
                end
            end
            if (depth_wr) begin
                depth <= next_depth;
            end
            // only codes 4 to 6 accepted
            if (bus_wr && AVS_ADDRESS == postproc_pkg::OFF_DIGITS
                && next_dig >= postproc_pkg::DIG_4P5
                && next_dig <= postproc_pkg::DIG_6P5) begin
                digits <= next_dig;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            for (int i = 0; i < 3; i++) begin
                gain[i] <= postproc_pkg::GAIN_RST;
                offs[i] <= postproc_pkg::OFFS_RST;
                rel[i] <= postproc_pkg::REL_RST;
            end
        end else if (CE && bus_wr && mdec[4]) begin
            if (mdec[1:0] == postproc_pkg::MATH_GAIN) begin
                gain[fidx_bus] <= new_word;
            end else if (mdec[1:0] == postproc_pkg::MATH_OFFS) begin
                offs[fidx_bus] <= new_word;
            end else begin
                rel[fidx_bus] <= new_word;
            end
        end
    end

    // stage 1: filter stack
    logic accept, bat_now, filt_now, refill;
    logic signed [31:0] x_in, x_other;
    logic signed [32:0] diff, mag;
    logic signed [SUM_W-1:0] depth_s, x_ext, old_ext;

    // one strobe per reading; a strobe right behind an accepted one is dropped
    assign accept = RD_VALID && !st1.valid;
    assign bat_now = is_bat(func);
    // voltage is processed only in the voltage function
    assign x_in = (func == postproc_pkg::FN_VOLT) ? RD_VOLTAGE : RD_CURRENT;
    assign x_other = (func == postproc_pkg::FN_VOLT) ? RD_CURRENT : RD_VOLTAGE;
    assign filt_now = filt_en && !bat_now;
    assign diff = 33'(x_in) - 33'(filt_value);
    assign mag = diff[32] ? -diff : diff;
    assign refill = empty || (win_sel != postproc_pkg::WIN_100
        && mag > win_hw(RD_RANGE, win_sel));
    assign depth_s = SUM_W'(depth);
    assign x_ext = SUM_W'(x_in);
    assign old_ext = SUM_W'(stack[ptr]);

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            for (int i = 0; i < DEPTH_CAP; i++) begin
                stack[i] <= 32'h0000_0000;
            end
            sum <= '0;
            ptr <= 7'h00;
            empty <= 1'b1;
        end else if (CE) begin
            // disable, depth change, function change or clear
            if (!filt_en || depth_wr || clear_wr
                || (ctrl_wr && next_fn != func)) begin
                empty <= 1'b1;
            end else if (accept && filt_now) begin
                empty <= 1'b0;
                if (refill) begin
                    for (int i = 0; i < DEPTH_CAP; i++) begin
                        stack[i] <= x_in;
                    end
                    sum <= SUM_W'(x_ext * depth_s);
                    ptr <= 7'h00;
                end else begin
                    stack[ptr] <= x_in;
                    sum <= sum - old_ext + x_ext;
                    ptr <= (ptr == depth - 7'h01) ? 7'h00 : ptr + 7'h01;
                end
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            st1 <= '0;
        end else if (CE) begin
            st1.valid <= accept;
            if (accept) begin
                st1.bat <= bat_now;
                st1.filt <= filt_now;
                st1.func <= func;
                // digit setting captured with the reading
                st1.digits <= digits;
                st1.prim <= x_in;
                st1.pre <= x_in;
                st1.other <= x_other;
            end
        end
    end

    // stage 2: mean and relative offset
    logic signed [SUM_W-1:0] mean;
    logic signed [31:0] x2;
    logic [1:0] fidx1, fidx2;

    // mean over depth; a refilled stack gives the reading
    assign mean = sum / depth_s;
    assign fidx1 = is_bat(st1.func) ? 2'h0 : st1.func[1:0];
    assign x2 = st1.filt ? mean[31:0] : st1.prim;

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            st2 <= '0;
            filt_value <= 32'h0000_0000;
        end else if (CE) begin
            st2.valid <= st1.valid;
            if (st1.valid) begin
                st2 <= st1;
                // filter value updated from every filtered reading
                if (st1.filt) begin
                    filt_value <= mean[31:0];
                end
                if (rel_en && !st1.bat) begin
                    st2.prim <= x2 - rel[fidx1];
                    st2.pre <= x2 - rel[fidx1];
                end else begin
                    st2.prim <= x2;
                    st2.pre <= x2;
                end
            end
        end
    end

    // stage 3: gain and offset
    logic signed [63:0] prod;
    localparam int GAIN_FRAC_HI = postproc_pkg::GAIN_FRAC + 31;

    assign fidx2 = is_bat(st2.func) ? 2'h0 : st2.func[1:0];
    assign prod = gain[fidx2] * st2.prim;

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            st3 <= '0;
        end else if (CE) begin
            st3.valid <= st2.valid;
            if (st2.valid) begin
                st3 <= st2;
                // math on the processed channel only
                if (math_en && !st2.bat) begin
                    st3.prim <= prod[GAIN_FRAC_HI:postproc_pkg::GAIN_FRAC]
                        + offs[fidx2];
                end
            end
        end
    end

    // stage 4: outputs
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            OUT_VALID <= 1'b0;
            OUT_VOLTAGE <= 32'h0000_0000;
            OUT_CURRENT <= 32'h0000_0000;
            BUF_VALUE <= 32'h0000_0000;
            OUT_DIGITS <= postproc_pkg::DIGITS_RST;
            result <= 32'h0000_0000;
        end else if (CE) begin
            // valid pulse four edges after the strobe
            OUT_VALID <= st3.valid;
            if (st3.valid) begin
                result <= st3.prim;
                if (st3.func == postproc_pkg::FN_VOLT) begin
                    OUT_VOLTAGE <= st3.prim;
                    OUT_CURRENT <= st3.other;
                end else begin
                    OUT_CURRENT <= st3.prim;
                    OUT_VOLTAGE <= st3.other;
                end
                BUF_VALUE <= buf_after ? st3.prim : st3.pre;
                OUT_DIGITS <= st3.bat ? postproc_pkg::DIG_6P5 : st3.digits;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            OUT_LAMP <= 1'b0;
            OUT_UNIT_X <= 1'b0;
        end else if (CE) begin
            // lamp follows filter or math enable
            OUT_LAMP <= filt_en || math_en;
            OUT_UNIT_X <= math_en && !bat_now;
        end
    end

endmodule

// ===== testbench/postproc_checker.sv
`timescale 1ns/1ps
module postproc_checker (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic NRST,
    // register bus
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic AVS_WAITREQUEST,
    // reading stream
    input wire logic RD_VALID,
    input wire logic OUT_VALID,
    input wire logic signed [31:0] OUT_VOLTAGE,
    input wire logic signed [31:0] OUT_CURRENT,
    input wire logic [2:0] OUT_DIGITS,
    input wire logic OUT_UNIT_X,
    input wire logic OUT_LAMP
);
    logic took;
    logic take;

    // a strobe right after an accepted one is dropped by the design
    assign take = RD_VALID && !took;

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            took <= 1'b0;
        end else begin
            took <= take;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);

    sequence s_take;
        take;
    endsequence

    sequence s_result;
        ##4 OUT_VALID;
    endsequence

    a_read_latency: assert property (s_take |-> s_result)
        else $error("no result four cycles after a strobe");
    a_valid_source: assert property (OUT_VALID |-> $past(take, 4))
        else $error("result without an accepted strobe");
    a_valid_pulse: assert property (OUT_VALID |=> !OUT_VALID)
        else $error("result valid longer than one cycle");
    a_digits_legal: assert property (
        OUT_DIGITS inside {3'h4, 3'h5, 3'h6})
        else $error("digit code outside four to six");
    a_digits_hold: assert property (!OUT_VALID |-> $stable(OUT_DIGITS))
        else $error("digit count changed without a new reading");
    a_data_hold: assert property (!OUT_VALID |->
        $stable({OUT_VOLTAGE, OUT_CURRENT}))
        else $error("result data changed between results");
    a_wait_ack: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
        |=> !AVS_WAITREQUEST)
        else $error("bus request not answered next cycle");
    a_wait_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low longer than one cycle");
    a_unit_lamp: assert property (OUT_UNIT_X |-> OUT_LAMP)
        else $error("unit shows X while lamp is dark");
endmodule

// ===== testbench/reading_source.sv
`timescale 1ns/1ps
module reading_source #(
    parameter logic [31:0] RANGE = 32'h0001_0000
) (
    // clock
    input wire logic clk,
    // converter lines
    output logic rd_valid,
    output logic signed [31:0] rd_voltage,
    output logic signed [31:0] rd_current,
    output logic [31:0] rd_range
);
    initial begin
        rd_valid = 1'b0;
        rd_voltage = 32'h0;
        rd_current = 32'h0;
        rd_range = RANGE;
    end

    task automatic send(input logic signed [31:0] v,
                        input logic signed [31:0] c);
        @(posedge clk);
        rd_valid <= 1'b1;
        rd_voltage <= v;
        rd_current <= c;
        @(posedge clk);
        rd_valid <= 1'b0;
        // data lines are meaningless after the strobe
        rd_voltage <= ~v;
        rd_current <= ~c;
    endtask
endmodule

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
    localparam logic [31:0] RANGE = 32'h0001_0000;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata, rd_range, q;
    logic waitreq, rd_valid, out_valid, unit_x, lamp;
    logic signed [31:0] rd_v, rd_c, out_v, out_c, buf_v, last;
    logic [2:0] digits;
    logic signed [31:0] stack [0:99];
    int err_total = 0;
    int comparisons = 0;
    int depth = 10;
    int win = 4;
    bit empty = 1'b1;
    longint lim = 0;

    always #5 clk = ~clk;

    reading_source #(.RANGE(RANGE)) i_reading_source (.clk(clk),
        .rd_valid(rd_valid), .rd_voltage(rd_v), .rd_current(rd_c),
        .rd_range(rd_range));

    reading_postprocess_pipeline i_reading_postprocess_pipeline (
        .REF_CLK(clk), .NRST(nrst), .CE(1'b1), .AVS_ADDRESS(address),
        .AVS_READ(read), .AVS_WRITE(write), .AVS_WRITEDATA(writedata),
        .AVS_BYTEENABLE(4'hf), .AVS_READDATA(readdata),
        .AVS_WAITREQUEST(waitreq), .RD_VALID(rd_valid), .RD_VOLTAGE(rd_v),
        .RD_CURRENT(rd_c), .RD_RANGE(rd_range), .OUT_VALID(out_valid),
        .OUT_VOLTAGE(out_v), .OUT_CURRENT(out_c), .BUF_VALUE(buf_v),
        .OUT_DIGITS(digits), .OUT_UNIT_X(unit_x), .OUT_LAMP(lamp));

    task automatic stop_test();
        if (err_total == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_val({31'h0, got}, {31'h0, exp});
    endtask

    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        write <= w;
        read <= !w;
        writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        chk_bit(n < 50, 1'b1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        chk_val(q, e);
    endtask

    // expected moving average with window refill
    function automatic logic signed [31:0] filt(input logic signed [31:0] x);
        longint sum;
        longint d;
        sum = 0;
        d = longint'(x) - longint'(last);
        if (empty || (win != 4 && (d > lim || -d > lim))) begin
            for (int i = 0; i < depth; i++) begin
                stack[i] = x;
            end
        end else begin
            for (int i = depth - 1; i > 0; i--) begin
                stack[i] = stack[i - 1];
            end
            stack[0] = x;
        end
        empty = 1'b0;
        for (int i = 0; i < depth; i++) begin
            sum += stack[i];
        end
        last = 32'(sum / depth);
        return last;
    endfunction

    task automatic reading(input logic signed [31:0] v, c, ev, ec);
        int n;
        n = 0;
        i_reading_source.send(v, c);
        do begin
            @(posedge clk);
            n++;
        end while (out_valid !== 1'b1 && n < 10);
        chk_bit(out_valid, 1'b1);
        chk_val(out_v, ev);
        chk_val(out_c, ec);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        chk_val(32'(digits), 32'h6);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0000_000a);
        rd(8'h08, 32'h6);
        rd(8'h30, 32'h0001_0000);
        rd(8'h2c, 32'h0);
        wr(8'h08, 32'h7);
        rd(8'h08, 32'h6);
        for (int k = 4; k <= 6; k++) begin
            wr(8'h08, 32'(k));
            chk_val(32'(digits), 32'((k == 4) ? 6 : k - 1));
            reading(32'(100 + k), -32'sd3, 32'(100 + k), -32'sd3);
            chk_val(32'(digits), 32'(k));
        end
        wr(8'h04, 32'h4);
        depth = 4;
        wr(8'h00, 32'h0000_2041);
        for (int k = 1; k <= 5; k++) begin
            reading(32'(7 * k), 32'(100 * k), 32'(7 * k),
                    filt(32'(100 * k)));
        end
        chk_bit(lamp, 1'b1);
        rd(8'h10, 32'h0000_0061);
        wr(8'h04, 32'h65);
        rd(8'h04, 32'h4);
        wr(8'h04, 32'h64);
        depth = 100;
        for (int w = 0; w <= 4; w++) begin
            win = w;
            lim = longint'(RANGE) / (10 ** (4 - w));
            wr(8'h00, 32'h0000_1001 | 32'(w << 4));
            wr(8'h0c, 32'h1);
            empty = 1'b1;
            reading(32'sd5, 32'sd0, 32'sd5, filt(32'sd0));
            reading(32'sd5, 32'(lim), 32'sd5, filt(32'(lim)));
            reading(32'sd5, 32'(3 * lim), 32'sd5,
                    filt(32'(3 * lim)));
        end
        wr(8'h00, 32'h0000_1000);
        reading(32'sd1, 32'sd40, 32'sd1, 32'sd40);
        chk_bit(lamp, 1'b0);
        wr(8'h00, 32'h0000_1041);
        empty = 1'b1;
        reading(32'sd1, 32'sd50, 32'sd1, filt(32'sd50));
        wr(8'h30, 32'h0002_0000);
        wr(8'h34, 32'h5);
        wr(8'h38, 32'ha);
        wr(8'h00, 32'h0000_1006);
        reading(32'sd3, 32'sd100, 32'sd3, 32'sd185);
        chk_val(buf_v, 32'sd90);
        chk_bit(unit_x, 1'b1);
        rd(8'h14, 32'd185);
        wr(8'h00, 32'h0000_1106);
        reading(32'sd3, 32'sd100, 32'sd3, 32'sd185);
        chk_val(buf_v, 32'sd185);
        wr(8'h00, 32'h0000_0006);
        reading(32'sd77, 32'sd100, 32'sd77, 32'sd100);
        wr(8'h08, 32'h4);
        for (int f = 3; f <= 4; f++) begin
            wr(8'h00, 32'h0000_0107 | 32'(f << 12));
            reading(-32'sd9, 32'sd100, -32'sd9, 32'sd100);
            chk_val(32'(digits), 32'h6);
            chk_bit(unit_x, 1'b0);
        end
        rd(8'h10, 32'h0000_0063);
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        stop_test();
    end
endmodule

bind reading_postprocess_pipeline postproc_checker i_postproc_checker (
    .REF_CLK(REF_CLK), .NRST(NRST), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .RD_VALID(RD_VALID), .OUT_VALID(OUT_VALID), .OUT_VOLTAGE(OUT_VOLTAGE),
    .OUT_CURRENT(OUT_CURRENT), .OUT_DIGITS(OUT_DIGITS),
    .OUT_UNIT_X(OUT_UNIT_X), .OUT_LAMP(OUT_LAMP));
